// >>> logic/isam_top.sv
// Function
// - flag request held back by cpu priority
// - hold set: vector shows highest pending
// - hold clear: vector keeps last acknowledged
// - cpu level shown at bits 11-8
// - vector code is number plus four
// - bits 12 and 7 read zero
// - reset sets source priorities to four
// - nesting disable blocks preemption by user sources, not by traps
// - request needs flag, enable, nonzero priority
// - flag still set retakes after return
// - return restores previous cpu level
// - trap retaken until its flag cleared
// - level seven blocks all user sources
// - traps masked only by cpu level eight or above
// - timed disable masks levels one to six
// - acknowledge only strictly above cpu level
// - priority zero disables, seven highest
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module isam_top #(
   parameter int N_SRC   = 8,
   parameter int TIMED_INTR_DISABLE_INSTR_CW = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cpu_ack,
   input  wire logic        cpu_return,
   output logic             irq_req,
   output logic [6:0]       irq_vec_code,
   output logic [3:0]       irq_level,
   output logic [3:0]       cpu_level_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [N_SRC-1:0]   flag_reg,   flag_next;
   logic [N_SRC-1:0]   en_reg,     en_next;
   logic [3*N_SRC-1:0] prio_reg,   prio_next;
   logic               vector_hold_select_reg,  vector_hold_select_next;
   logic               nest_reg,   nest_next;
   logic               trap_reg,   trap_next;
   logic [3:0]         level_reg,  level_next;
   logic [3:0]         saved_reg,  saved_next;
   logic               busy_reg,   busy_next;
   logic [6:0]         last_reg,   last_next;
   logic [31:0]        rdata_reg,  rdata_next;
   logic               ready_reg,  ready_next;
   logic               err_reg,    err_next;
   logic               irq_reg,    irq_next;
   logic [6:0]         ivec_reg,   ivec_next;
   logic [3:0]         ilvl_reg,   ilvl_next;
   logic               unack_reg,  unack_next;

   logic [N_SRC-1:0]   req_vec;
   isam_pkg::isam_pick_t pick_u, pick;
   logic               timed_intr_disable_instr_on, timed_intr_disable_instr_start;
   logic               wr_en, rd_en;
   logic               allowed;

   function automatic logic [31:0] wzx(input logic [15:0] v);
      wzx = {16'h0000, v};
   endfunction

   // source priority window: one word per source
   function automatic logic prio_hit(input logic [11:0] a);
      prio_hit = (a >= isam_pkg::ADDR_PRIO0) && (a < isam_pkg::ADDR_PRIO0 + 12'(4 * N_SRC));
   endfunction

   // bit offset of a source's field within prio_reg
   function automatic int prio_base(input logic [11:0] a);
      prio_base = 3 * int'((a - isam_pkg::ADDR_PRIO0) >> 2);
   endfunction

   // ----------------------------------------------------------------
   // request selection
   // ----------------------------------------------------------------
   // a source with priority zero is off and never counts as pending
   always_comb
   begin
      for (int i = 0; i < N_SRC; i++)
         req_vec[i] = flag_reg[i] && en_reg[i] && prio_reg[3*i +: 3] != 3'h0;
   end

   isam_arbiter #(.N_SRC(N_SRC)) u_arb (
      .req_vec  (req_vec),
      .prio_vec (prio_reg),
      .pick     (pick_u)
   );

   isam_timed_intr_disable_instr_timer #(.CW(TIMED_INTR_DISABLE_INSTR_CW)) u_timed_intr_disable_instr (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (timed_intr_disable_instr_start),
      .count   (pwdata[TIMED_INTR_DISABLE_INSTR_CW-1:0]),
      .active  (timed_intr_disable_instr_on)
   );

   always_comb
   begin
      pick = pick_u;
      if (trap_reg)
      begin
         pick.valid    = 1'b1;
         pick.level    = isam_pkg::LEVEL_TRAP;
         pick.vec_code = 7'h00;
      end
   end

   // prio zero never qualifies since level must exceed cpu level >= 0
   always_comb
   begin
      allowed = pick.valid && (pick.level > level_reg);
      if (timed_intr_disable_instr_on && pick.level <= isam_pkg::LEVEL_TIMED_INTR_DISABLE_INSTR_MAX)
         allowed = 1'b0;
      if (nest_reg && busy_reg && pick.level < isam_pkg::LEVEL_TRAP)
         allowed = 1'b0;
   end

   assign wr_en      = psel && penable && pwrite;
   assign rd_en      = psel && penable && !pwrite;
   assign timed_intr_disable_instr_start = wr_en && paddr == isam_pkg::ADDR_TIMED_INTR_DISABLE_INSTR;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      flag_next  = flag_reg;
      en_next    = en_reg;
      prio_next  = prio_reg;
      vector_hold_select_next = vector_hold_select_reg;
      nest_next  = nest_reg;
      trap_next  = trap_reg;
      level_next = level_reg;
      saved_next = saved_reg;
      busy_next  = busy_reg;
      last_next  = last_reg;
      rdata_next = 32'h0000_0000;
      ready_next = 1'b0;
      err_next   = 1'b0;
      if (psel && !penable)
         ready_next = 1'b1;
      if (wr_en)
      begin
         case (paddr)
            isam_pkg::ADDR_STATUS:   vector_hold_select_next = pwdata[isam_pkg::BIT_VECTOR_HOLD_SELECT];
            isam_pkg::ADDR_CTRL_ONE:
            begin
               // software may raise the trap flag to inject a trap; the handler clears it
               nest_next = pwdata[isam_pkg::BIT_NEST_DIS];
               trap_next = pwdata[isam_pkg::BIT_TRAP_FLAG];
            end
            isam_pkg::ADDR_FLAG:     flag_next  = pwdata[N_SRC-1:0];
            isam_pkg::ADDR_ENABLE:   en_next    = pwdata[N_SRC-1:0];
            isam_pkg::ADDR_CPU:      level_next = pwdata[3:0];
            isam_pkg::ADDR_TIMED_INTR_DISABLE_INSTR:     ;
            default:
            begin
               if (prio_hit(paddr))
                  prio_next[prio_base(paddr) +: 3] = pwdata[2:0];
               else
                  err_next = psel && !penable;
            end
         endcase
      end
      if (psel && !penable)
      begin
         case (paddr)
            isam_pkg::ADDR_STATUS:
               rdata_next = wzx({unack_reg, 1'b0, vector_hold_select_reg, 1'b0, level_reg, 1'b0,
                                 vector_hold_select_reg ? pick.vec_code : last_reg});
            isam_pkg::ADDR_CTRL_ONE: rdata_next = wzx({nest_reg, 14'h0000, trap_reg});
            isam_pkg::ADDR_FLAG:     rdata_next = 32'(flag_reg);
            isam_pkg::ADDR_ENABLE:   rdata_next = 32'(en_reg);
            isam_pkg::ADDR_CPU:      rdata_next = 32'(level_reg);
            isam_pkg::ADDR_TIMED_INTR_DISABLE_INSTR:     rdata_next = 32'(timed_intr_disable_instr_on);
            default:
            begin
               if (prio_hit(paddr))
                  rdata_next = 32'(prio_reg[prio_base(paddr) +: 3]);
               else
                  err_next = 1'b1;
            end
         endcase
      end
      // acknowledge: save level, raise to source level; flag stays set for retake
      if (cpu_ack && irq_reg)
      begin
         saved_next = level_reg;
         level_next = ilvl_reg;
         busy_next  = 1'b1;
         last_next  = ivec_reg;
      end
      else if (cpu_return)
      begin
         level_next = saved_reg;
         busy_next  = 1'b0;
      end
   end

   // request outputs: presented until acknowledged
   always_comb
   begin
      irq_next   = allowed && !(cpu_ack && irq_reg);
      ivec_next  = pick.vec_code;
      ilvl_next  = pick.level;
      unack_next = pick.valid && !allowed;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         flag_reg  <= '0;
         en_reg    <= '0;
         prio_reg  <= {N_SRC{isam_pkg::PRIO_RESET}};
         vector_hold_select_reg <= 1'b0;
         nest_reg  <= 1'b0;
         trap_reg  <= 1'b0;
         level_reg <= 4'h0;
         saved_reg <= 4'h0;
         busy_reg  <= 1'b0;
         last_reg  <= 7'h00;
         rdata_reg <= 32'h0000_0000;
         ready_reg <= 1'b0;
         err_reg   <= 1'b0;
         irq_reg   <= 1'b0;
         ivec_reg  <= 7'h00;
         ilvl_reg  <= 4'h0;
         unack_reg <= 1'b0;
      end
      else
      begin
         flag_reg  <= flag_next;
         en_reg    <= en_next;
         prio_reg  <= prio_next;
         vector_hold_select_reg <= vector_hold_select_next;
         nest_reg  <= nest_next;
         trap_reg  <= trap_next;
         level_reg <= level_next;
         saved_reg <= saved_next;
         busy_reg  <= busy_next;
         last_reg  <= last_next;
         rdata_reg <= rdata_next;
         ready_reg <= ready_next;
         err_reg   <= err_next;
         irq_reg   <= irq_next;
         ivec_reg  <= ivec_next;
         ilvl_reg  <= ilvl_next;
         unack_reg <= unack_next;
      end
   end

   assign prdata        = rdata_reg;
   assign pready        = ready_reg;
   assign pslverr       = err_reg;
   assign irq_req       = irq_reg;
   assign irq_vec_code  = ivec_reg;
   assign irq_level     = ilvl_reg;
   assign cpu_level_out = level_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // all checks run on the system clock and sleep through reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_ACK_ABOVE_LEVEL: assert property (irq_req |-> irq_level > $past(level_reg))
      else $error("request level not above cpu level");
   AST_USER_MASK7: assert property (level_reg == 4'h7 && !trap_reg |=> !irq_req)
      else $error("user request while cpu level seven");
   AST_TRAP_UNMASKED: assert property (trap_reg && level_reg < 4'h8 && !(nest_reg && busy_reg)
      && !(cpu_ack && irq_reg) |=> irq_req)
      else $error("trap masked");
   AST_TIMED_INTR_DISABLE_INSTR: assert property (timed_intr_disable_instr_on && pick.level <= 4'h6 |=> !irq_req)
      else $error("timed disable leaked request");
   AST_RETURN: assert property (cpu_return && !(cpu_ack && irq_reg) |=> level_reg == $past(saved_reg))
      else $error("return did not restore level");
   AST_ACK_LAST: assert property (cpu_ack && irq_reg |=> last_reg == $past(ivec_reg))
      else $error("last vector not captured");
   AST_UNACK: assert property (pick.valid && !allowed |=> unack_reg)
      else $error("unacked flag missing");
   AST_NEST: assert property (nest_reg && busy_reg && !trap_reg |=> !irq_req)
      else $error("nesting not blocked");
   AST_READY: assert property (psel && !penable |=> pready)
      else $error("apb not ready");
   COV_ACK: cover property (irq_req ##1 cpu_ack);
   COV_TIMED_INTR_DISABLE_INSTR: cover property (timed_intr_disable_instr_start ##1 timed_intr_disable_instr_on);
   COV_TRAP: cover property (trap_reg && irq_req);
   COV_NEST: cover property (nest_reg && busy_reg && unack_reg);
   COV_RETURN: cover property (cpu_return ##1 irq_req);
endmodule // isam_top

// >>> logic/isam_pkg.sv
package isam_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_STATUS   = 12'h000;
   localparam logic [11:0] ADDR_CTRL_ONE = 12'h004;
   localparam logic [11:0] ADDR_FLAG     = 12'h008;
   localparam logic [11:0] ADDR_ENABLE   = 12'h00C;
   localparam logic [11:0] ADDR_CPU      = 12'h010;
   localparam logic [11:0] ADDR_TIMED_INTR_DISABLE_INSTR     = 12'h014;
   localparam logic [11:0] ADDR_PRIO0    = 12'h040;
   // ----------------------------------------------------------------
   // status and control one register fields
   // ----------------------------------------------------------------
   localparam int BIT_REQ_UNACKED = 15;
   localparam int BIT_VECTOR_HOLD_SELECT       = 13;
   localparam int POS_LEVEL       = 8;
   localparam int BIT_NEST_DIS    = 15;
   localparam int BIT_TRAP_FLAG   = 0;
   // ----------------------------------------------------------------
   // reset values and constants
   // ----------------------------------------------------------------
   localparam logic [2:0] PRIO_RESET   = 3'h4;
   localparam logic [3:0] LEVEL_USER_MAX = 4'h7;
   localparam logic [3:0] LEVEL_TIMED_INTR_DISABLE_INSTR_MAX = 4'h6;
   localparam logic [3:0] LEVEL_TRAP   = 4'h8;
   localparam logic [6:0] VEC_USER_BASE = 7'h04;
   localparam int         TIMED_INTR_DISABLE_INSTR_CYCLES_DEF = 16;

   typedef struct packed {
      logic [6:0] vec_code;
      logic [3:0] level;
      logic       valid;
   } isam_pick_t;
endpackage

// >>> logic/isam_arbiter.sv
`timescale 1ns/1ps
module isam_arbiter #(
   parameter int N_SRC = 8
) (
   input  wire logic [N_SRC-1:0]   req_vec,
   input  wire logic [3*N_SRC-1:0] prio_vec,
   output isam_pkg::isam_pick_t    pick
);
   // lowest index wins among equal priorities
   always_comb
   begin
      pick = '0;
      for (int i = N_SRC - 1; i >= 0; i--)
      begin
         if (req_vec[i] && ({1'b0, prio_vec[3*i +: 3]} >= pick.level || !pick.valid))
         begin
            pick.valid    = 1'b1;
            pick.level    = {1'b0, prio_vec[3*i +: 3]};
            pick.vec_code = 7'(i) + isam_pkg::VEC_USER_BASE;
         end
      end
   end
endmodule // isam_arbiter

// >>> logic/isam_timed_intr_disable_instr_timer.sv
`timescale 1ns/1ps
module isam_timed_intr_disable_instr_timer #(
   parameter int CW = 16
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          start,
   input  wire logic [CW-1:0] count,
   output logic               active
);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (start)
         cnt_next = count;
      else if (cnt_reg != '0)
         cnt_next = cnt_reg - 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign active = (cnt_reg != '0);
endmodule // isam_timed_intr_disable_instr_timer

// >>> tb/isam_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// cpu core: takes requests after a programmable delay
// ------------------------------------------------------------
module isam_cpu_model (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       irq_req,
   input  wire logic       take_en,
   input  wire logic [1:0] wait_cyc,
   input  wire logic       ret_go,
   output logic            cpu_ack,
   output logic            cpu_return
);
   logic [1:0] cnt_reg;

   always @(posedge sys_clk)
   begin
      cpu_return <= ret_go & !rst;
      if (rst || cpu_ack)
      begin
         cpu_ack <= 1'b0;
         cnt_reg <= 2'h0;
      end
      else if (irq_req && take_en)
      begin
         // ack only while the request is presented
         if (cnt_reg >= wait_cyc) cpu_ack <= 1'b1;
         else cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule // isam_cpu_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic        sys_clk, rst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic        pready, pslverr, cpu_ack, cpu_return, irq_req;
   logic        take_en, ret_go;
   logic [1:0]  wait_cyc;
   logic [6:0]  irq_vec_code;
   logic [3:0]  irq_level, cpu_level_out;
   logic [32:0] rdq[$];
   logic [10:0] akq[$];
   int          miscompares, tests_run, acks, cyc;

   isam_top u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
      .irq_req(irq_req), .irq_vec_code(irq_vec_code), .irq_level(irq_level),
      .cpu_level_out(cpu_level_out));
   isam_cpu_model u_cpu (.sys_clk(sys_clk), .rst(rst), .irq_req(irq_req),
      .take_en(take_en), .wait_cyc(wait_cyc), .ret_go(ret_go), .cpu_ack(cpu_ack),
      .cpu_return(cpu_return));

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic chk(input logic [32:0] e, input logic [32:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
         miscompares++;
      end
   endtask

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rdq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic wait_acks(input int n);
      int k;
      k = 0;
      while (acks < n && k < 200)
      begin
         @(posedge sys_clk);
         k++;
      end
      chk(33'(n), 33'(acks));
   endtask

   task automatic ret;
      @(posedge sys_clk) ret_go <= 1'b1;
      @(posedge sys_clk) ret_go <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   // ------------------------------------------------------------
   // monitor: oldest note against each result
   // ------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         print_verdict();
      end
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (rdq.size() == 0) chk(33'h0, 33'h1);
         else if (rdq[0][32]) chk(rdq.pop_front(), {pslverr, 32'h0});
         else chk(rdq.pop_front(), {pslverr, prdata});
      end
      if (cpu_ack === 1'b1 && irq_req === 1'b1)
      begin
         acks++;
         if (akq.size() == 0) chk(33'h0, 33'h1);
         else chk(33'(akq.pop_front()), 33'({irq_vec_code, irq_level}));
      end
   end

   initial
   begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; take_en = 1'b1; ret_go = 1'b0; wait_cyc = 2'h0;
      seed = 32'h45b0_7f6d; miscompares = 0; tests_run = 0; acks = 0; cyc = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(isam_pkg::ADDR_PRIO0 + 12'(4 * i), 33'h4);
      rd(isam_pkg::ADDR_STATUS, 33'h0);
      rd(12'h020, 33'h1_0000_0000);
      $display("test 1 done");
      seed = xs(seed);
      wait_cyc <= seed[1:0];
      akq.push_back({7'h07, 4'h4});
      akq.push_back({7'h07, 4'h4});
      wr(isam_pkg::ADDR_ENABLE, 32'h0000_0008);
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0008);
      wait_acks(1);
      repeat (2) @(posedge sys_clk);
      chk(33'h4, 33'(cpu_level_out));
      ret();
      wait_acks(2);
      wr(isam_pkg::ADDR_FLAG, 32'h0);
      ret();
      ret();
      chk(33'h0, 33'(cpu_level_out));
      $display("test 2 done");
      seed = xs(seed);
      wait_cyc <= seed[1:0];
      akq.push_back({7'h05, 4'h5});
      wr(isam_pkg::ADDR_PRIO0, 32'h0);
      wr(isam_pkg::ADDR_PRIO0 + 12'h004, 32'h0000_0005);
      wr(isam_pkg::ADDR_PRIO0 + 12'h008, 32'h0000_0005);
      wr(isam_pkg::ADDR_ENABLE, 32'h0000_0007);
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0007);
      wait_acks(3);
      wr(isam_pkg::ADDR_FLAG, 32'h0);
      ret();
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0001);
      rd(isam_pkg::ADDR_STATUS, 33'h0_0000_0005);
      $display("test 3 done");
      wr(isam_pkg::ADDR_CPU, 32'h0000_0007);
      wr(isam_pkg::ADDR_PRIO0 + 12'h008, 32'h0000_0007);
      wr(isam_pkg::ADDR_ENABLE, 32'h0000_0004);
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0004);
      repeat (10) @(posedge sys_clk);
      chk(33'h0, 33'(irq_req));
      rd(isam_pkg::ADDR_STATUS, 33'h0_0000_8705);
      wr(isam_pkg::ADDR_STATUS, 32'h0000_3080);
      rd(isam_pkg::ADDR_STATUS, 33'h0_0000_a706);
      akq.push_back({7'h06, 4'h7});
      wr(isam_pkg::ADDR_CPU, 32'h0000_0006);
      wait_acks(4);
      wr(isam_pkg::ADDR_STATUS, 32'h0);
      wr(isam_pkg::ADDR_FLAG, 32'h0);
      rd(isam_pkg::ADDR_STATUS, 33'h0_0000_0706);
      ret();
      $display("test 4 done");
      wr(isam_pkg::ADDR_CPU, 32'h0);
      wr(isam_pkg::ADDR_PRIO0 + 12'h00c, 32'h0000_0006);
      wr(isam_pkg::ADDR_PRIO0 + 12'h010, 32'h0000_0007);
      wr(isam_pkg::ADDR_ENABLE, 32'h0000_0018);
      wr(isam_pkg::ADDR_TIMED_INTR_DISABLE_INSTR, 32'h0000_012c);
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0008);
      repeat (20) @(posedge sys_clk);
      chk(33'h0, 33'(irq_req));
      akq.push_back({7'h08, 4'h7});
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0018);
      wait_acks(5);
      wr(isam_pkg::ADDR_FLAG, 32'h0);
      ret();
      $display("test 5 done");
      wr(isam_pkg::ADDR_CPU, 32'h0000_0007);
      akq.push_back({7'h00, 4'h8});
      akq.push_back({7'h00, 4'h8});
      wr(isam_pkg::ADDR_CTRL_ONE, 32'h0000_0001);
      wait_acks(6);
      ret();
      wait_acks(7);
      wr(isam_pkg::ADDR_CTRL_ONE, 32'h0);
      ret();
      chk(33'h7, 33'(cpu_level_out));
      chk(33'h0, 33'(irq_req));
      $display("test 6 done");
      wr(isam_pkg::ADDR_TIMED_INTR_DISABLE_INSTR, 32'h0);
      wr(isam_pkg::ADDR_CPU, 32'h0);
      wr(isam_pkg::ADDR_CTRL_ONE, 32'h0000_8000);
      akq.push_back({7'h07, 4'h6});
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0008);
      wait_acks(8);
      wr(isam_pkg::ADDR_FLAG, 32'h0000_0018);
      repeat (10) @(posedge sys_clk);
      chk(33'h0, 33'(irq_req));
      akq.push_back({7'h08, 4'h7});
      wr(isam_pkg::ADDR_CTRL_ONE, 32'h0);
      wait_acks(9);
      wr(isam_pkg::ADDR_FLAG, 32'h0);
      ret();
      ret();
      $display("test 7 done");
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd(isam_pkg::ADDR_PRIO0 + 12'h004, 33'h4);
      seed = xs(seed);
      wr(isam_pkg::ADDR_STATUS, seed & 32'h0000_9fff);
      rd(isam_pkg::ADDR_STATUS, 33'h0);
      $display("test 8 done");
      print_verdict();
   end
endmodule // tb
